// ===== rtl/lnd_pkg.sv
// What this block does
// - one trip output per phase plus a general trip output
// - twelve binary channels sent to remote, twelve received channels reproduced
// - dedicated output flag shows communication channel failure
// - function enable gates all trips, disabled after reset
// - base sensitivity 10 to 50 percent, 1 percent steps, default 30
// - slope one 10-50 (30), slope two 50-100 (70), break bias 100-400 (200)
// - high-set level 500-1500 percent, default 800, trips regardless of bias
// - local and remote ratio factors 0.10 to 2.00, default 1.00
// - link settings must match on both ends; outside this block
// - transformer variant: high second harmonic of local current blocks operation
// - transformer variant: high fifth harmonic of local current blocks operation
// - local restraint sent to remote; remote restraint blocks like local one
// - each phase operates when its differential lies above the characteristic
// - unrestrained high-set stage evaluated from differential currents
// - restraint current taken from compensated currents of both ends
// - local phasors and restraint flag sent to remote, same set received
// - differential is magnitude of local plus remote phasor sum per phase
// - bias is largest of the six phase current magnitudes
// - block input disables the function and all trips
// - isolated bad frames tolerated; repeated ones fail; automatic recovery
package lnd_pkg;
    localparam int CW = 16;
    localparam int SW = 26;
    localparam int WW = 40;
    localparam int NCH = 12;
    localparam int FRAME_W = 6 * CW + 1 + NCH;
    localparam int FR_IM_POS = 3 * CW;
    localparam int FR_RST_POS = 6 * CW;
    localparam int FR_CH_POS = 6 * CW + 1;
    localparam int CUR_FRAC = 8;
    localparam logic [WW-1:0] PCT = 40'h64;
    localparam logic [7:0] BASE_DEF = 8'h1E;
    localparam logic [7:0] BASE_MIN = 8'h0A;
    localparam logic [7:0] BASE_MAX = 8'h32;
    localparam logic [7:0] S1_DEF = 8'h1E;
    localparam logic [7:0] S1_MIN = 8'h0A;
    localparam logic [7:0] S1_MAX = 8'h32;
    localparam logic [7:0] S2_DEF = 8'h46;
    localparam logic [7:0] S2_MIN = 8'h32;
    localparam logic [7:0] S2_MAX = 8'h64;
    localparam logic [9:0] BRK_DEF = 10'h0C8;
    localparam logic [9:0] BRK_MIN = 10'h064;
    localparam logic [9:0] BRK_MAX = 10'h190;
    localparam logic [10:0] HS_DEF = 11'h320;
    localparam logic [10:0] HS_MIN = 11'h1F4;
    localparam logic [10:0] HS_MAX = 11'h5DC;
    localparam logic [7:0] RATIO_DEF = 8'h64;
    localparam logic [7:0] RATIO_MIN = 8'h0A;
    localparam logic [7:0] RATIO_MAX = 8'hC8;
    localparam logic [7:0] H2_DEF = 8'h0F;
    localparam logic [7:0] H5_DEF = 8'h23;
    localparam logic [7:0] HARM_MIN = 8'h05;
    localparam logic [7:0] HARM_MAX = 8'h50;
    localparam logic [2:0] FAIL_CNT = 3'h3;
    localparam logic [2:0] RECOVER_CNT = 3'h3;
    localparam int RX_TIMEOUT_NS = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/lnd_trip_decision.sv
`timescale 1ns/1ps
module lnd_trip_decision
    import lnd_pkg::*;
#(
    parameter int RX_TIMEOUT = RX_TIMEOUT_CYC // silence limit, clocks
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_resetn, // async reset, active low
    input wire logic i_cfg_load, // take settings below
    input wire logic i_cfg_enable, // function enable
    input wire logic [7:0] i_cfg_base, // base sensitivity, percent
    input wire logic [7:0] i_cfg_slope_one, // percent
    input wire logic [7:0] i_cfg_slope_two, // percent
    input wire logic [9:0] i_cfg_slope_break_bias, // percent
    input wire logic [10:0] i_cfg_highset_diff_level, // percent
    input wire logic [7:0] i_cfg_local_ratio, // hundredths
    input wire logic [7:0] i_cfg_remote_ratio, // hundredths
    input wire logic [7:0] i_cfg_h2_level, // percent of fundamental
    input wire logic [7:0] i_cfg_h5_level, // percent of fundamental
    input wire logic i_xfmr_variant_function, // transformer variant
    input wire logic i_block, // disables function
    input wire logic i_sample_valid, // new local sample
    output logic o_sample_ready, // buffer can take a frame
    input wire logic [3*CW-1:0] i_loc_re, // local fundamental, real
    input wire logic [3*CW-1:0] i_loc_im, // local fundamental, imag
    input wire logic [3*CW-1:0] i_loc_h2_mag, // second harmonic magnitudes
    input wire logic [3*CW-1:0] i_loc_h5_mag, // fifth harmonic magnitudes
    input wire logic [NCH-1:0] i_remote_tx_bit, // channels to remote
    output logic o_tx_valid, // frame to link
    input wire logic i_tx_ready, // link takes frame
    output logic [FRAME_W-1:0] o_tx_data, // frame to link
    input wire logic i_rx_valid, // frame from link
    input wire logic i_rx_good, // frame passed integrity check
    input wire logic [FRAME_W-1:0] i_rx_data, // frame from link
    output logic o_phase1_trip_out, // trip phase 1
    output logic o_phase2_trip_out, // trip phase 2
    output logic o_phase3_trip_out, // trip phase 3
    output logic o_general_trip_out, // general trip
    output logic [NCH-1:0] o_remote_rx_bit, // channels from remote
    output logic o_link_failure_flag, // link failed
    output logic o_local_restraint // harmonic restraint sent
);
    if (RX_TIMEOUT < 2) begin : g_bad_timeout
        $error("RX_TIMEOUT must be at least 2");
    end

    function automatic logic signed [SW-1:0] comp(input logic signed [CW-1:0] raw,
                                                  input logic [7:0] ratio);
        logic signed [CW+8:0] prod;
        prod = raw * $signed({1'b0, ratio});
        return SW'(prod);
    endfunction

    function automatic logic [SW-1:0] absv(input logic signed [SW-1:0] v);
        logic [SW-1:0] a;
        a = v[SW-1] ? -v : v;
        return a;
    endfunction

    // alpha-max-beta-min, within about 7 percent, avoids a square root
    function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] re,
                                          input logic signed [SW-1:0] im);
        logic [SW-1:0] a, b, hi, lo;
        a = absv(re);
        b = absv(im);
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        return hi + (lo >> 2) + (lo >> 3);
    endfunction

    function automatic logic inr(input logic [10:0] v, input logic [10:0] lo,
                                 input logic [10:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic en_r;
    logic [7:0] base_r, s1_r, s2_r, lr_r, rr_r, h2_r, h5_r;
    logic [9:0] brk_r;
    logic [10:0] hs_r;

    // out-of-range values are refused field by field, old value kept
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_r <= 1'b0;
            base_r <= BASE_DEF;
            s1_r <= S1_DEF;
            s2_r <= S2_DEF;
            brk_r <= BRK_DEF;
            hs_r <= HS_DEF;
            lr_r <= RATIO_DEF;
            rr_r <= RATIO_DEF;
            h2_r <= H2_DEF;
            h5_r <= H5_DEF;
        end else if (i_cfg_load) begin
            en_r <= i_cfg_enable;
            if (inr(11'(i_cfg_base), 11'(BASE_MIN), 11'(BASE_MAX))) base_r <= i_cfg_base;
            if (inr(11'(i_cfg_slope_one), 11'(S1_MIN), 11'(S1_MAX))) s1_r <= i_cfg_slope_one;
            if (inr(11'(i_cfg_slope_two), 11'(S2_MIN), 11'(S2_MAX))) s2_r <= i_cfg_slope_two;
            if (inr(11'(i_cfg_slope_break_bias), 11'(BRK_MIN), 11'(BRK_MAX)))
                brk_r <= i_cfg_slope_break_bias;
            if (inr(i_cfg_highset_diff_level, HS_MIN, HS_MAX)) hs_r <= i_cfg_highset_diff_level;
            if (inr(11'(i_cfg_local_ratio), 11'(RATIO_MIN), 11'(RATIO_MAX)))
                lr_r <= i_cfg_local_ratio;
            if (inr(11'(i_cfg_remote_ratio), 11'(RATIO_MIN), 11'(RATIO_MAX)))
                rr_r <= i_cfg_remote_ratio;
            if (inr(11'(i_cfg_h2_level), 11'(HARM_MIN), 11'(HARM_MAX))) h2_r <= i_cfg_h2_level;
            if (inr(11'(i_cfg_h5_level), 11'(HARM_MIN), 11'(HARM_MAX))) h5_r <= i_cfg_h5_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic fail_r;
    logic [2:0] bad_cnt_r, good_cnt_r;
    logic [31:0] quiet_cnt_r;
    logic [3*CW-1:0] rem_re_r, rem_im_r;
    logic rem_rst_r;
    wire rx_ok = i_rx_valid && i_rx_good;

    // starts failed: no trust in the link until healthy frames arrive
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fail_r <= 1'b1;
            bad_cnt_r <= 3'h0;
            good_cnt_r <= 3'h0;
            quiet_cnt_r <= 32'h0;
        end else if (rx_ok) begin
            quiet_cnt_r <= 32'h0;
            bad_cnt_r <= 3'h0;
            if (fail_r) begin
                if (good_cnt_r == RECOVER_CNT - 3'h1) begin
                    fail_r <= 1'b0;
                    good_cnt_r <= 3'h0;
                end else begin
                    good_cnt_r <= good_cnt_r + 3'h1;
                end
            end
        end else begin
            if (i_rx_valid) begin
                good_cnt_r <= 3'h0;
                if (bad_cnt_r == FAIL_CNT - 3'h1) fail_r <= 1'b1;
                else bad_cnt_r <= bad_cnt_r + 3'h1;
            end
            if (quiet_cnt_r == 32'(RX_TIMEOUT - 1)) begin
                fail_r <= 1'b1;
                good_cnt_r <= 3'h0;
            end else begin
                quiet_cnt_r <= quiet_cnt_r + 32'h1;
            end
        end
    end

    // bad frames never overwrite remote data; the last good set is held
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rem_re_r <= '0;
            rem_im_r <= '0;
            rem_rst_r <= 1'b0;
        end else if (rx_ok) begin
            rem_re_r <= i_rx_data[FR_IM_POS-1:0];
            rem_im_r <= i_rx_data[FR_RST_POS-1:FR_IM_POS];
            rem_rst_r <= i_rx_data[FR_RST_POS];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_remote_rx_bit <= '0;
            o_link_failure_flag <= 1'b1;
        end else begin
            o_link_failure_flag <= fail_r;
            if (fail_r) o_remote_rx_bit <= '0;
            else if (rx_ok) o_remote_rx_bit <= i_rx_data[FRAME_W-1:FR_CH_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [SW-1:0] dmag [3];
    logic [2:0] op, hs, hb;
    logic [WW-1:0] bias, thr, brk_s, base_t;

    always_comb begin
        logic signed [SW-1:0] lre, lim, rre, rim;
        logic [SW-1:0] lmag, rmag, fmag;
        lre = '0;
        lim = '0;
        rre = '0;
        rim = '0;
        lmag = '0;
        rmag = '0;
        fmag = '0;
        bias = '0;
        for (int p = 0; p < 3; p++) begin
            lre = comp($signed(i_loc_re[p*CW +: CW]), lr_r);
            lim = comp($signed(i_loc_im[p*CW +: CW]), lr_r);
            rre = comp($signed(rem_re_r[p*CW +: CW]), rr_r);
            rim = comp($signed(rem_im_r[p*CW +: CW]), rr_r);
            dmag[p] = mag(lre + rre, lim + rim);
            lmag = mag(lre, lim);
            rmag = mag(rre, rim);
            if (WW'(lmag) > bias) bias = WW'(lmag);
            if (WW'(rmag) > bias) bias = WW'(rmag);
            fmag = mag(SW'($signed(i_loc_re[p*CW +: CW])), SW'($signed(i_loc_im[p*CW +: CW])));
            hb[p] = (WW'(i_loc_h2_mag[p*CW +: CW]) * PCT > WW'(h2_r) * WW'(fmag))
                 || (WW'(i_loc_h5_mag[p*CW +: CW]) * PCT > WW'(h5_r) * WW'(fmag));
        end
        // all currents carry the ratio in hundredths, so one percent is 1<<CUR_FRAC
        brk_s = WW'(brk_r) << CUR_FRAC;
        base_t = (WW'(base_r) * PCT) << CUR_FRAC;
        if (bias <= brk_s) thr = WW'(s1_r) * bias;
        else thr = WW'(s1_r) * brk_s + WW'(s2_r) * (bias - brk_s);
        if (thr < base_t) thr = base_t;
        for (int p = 0; p < 3; p++) begin
            op[p] = WW'(dmag[p]) * PCT > thr;
            hs[p] = WW'(dmag[p]) > (WW'(hs_r) << CUR_FRAC);
        end
    end

    wire rst_loc = i_xfmr_variant_function && (|hb);
    wire rst_all = rst_loc || (i_xfmr_variant_function && rem_rst_r);
    wire live = en_r && !i_block && !fail_r;
    wire [2:0] trip_nxt = {3{live}} & ((op & {3{!rst_all}}) | hs);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_phase1_trip_out <= 1'b0;
            o_phase2_trip_out <= 1'b0;
            o_phase3_trip_out <= 1'b0;
            o_general_trip_out <= 1'b0;
            o_local_restraint <= 1'b0;
        end else begin
            o_phase1_trip_out <= trip_nxt[0];
            o_phase2_trip_out <= trip_nxt[1];
            o_phase3_trip_out <= trip_nxt[2];
            o_general_trip_out <= |trip_nxt;
            o_local_restraint <= rst_loc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry buffer toward the link; a stalled link drops o_sample_ready
    logic [FRAME_W-1:0] tail_r;
    logic tail_v_r, hv_nxt, tv_nxt, ld_head_tail, ld_head_new, ld_tail_new;
    wire push = i_sample_valid && o_sample_ready;
    wire pop = o_tx_valid && i_tx_ready;
    wire [FRAME_W-1:0] frame = {i_remote_tx_bit, rst_loc, i_loc_im, i_loc_re};

    always_comb begin
        hv_nxt = o_tx_valid;
        tv_nxt = tail_v_r;
        ld_head_tail = 1'b0;
        ld_head_new = 1'b0;
        ld_tail_new = 1'b0;
        if (pop) begin
            if (tail_v_r) begin
                ld_head_tail = 1'b1;
                tv_nxt = push;
                ld_tail_new = push;
            end else begin
                hv_nxt = push;
                ld_head_new = push;
            end
        end else if (push) begin
            if (o_tx_valid) begin
                tv_nxt = 1'b1;
                ld_tail_new = 1'b1;
            end else begin
                hv_nxt = 1'b1;
                ld_head_new = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_valid <= 1'b0;
            tail_v_r <= 1'b0;
            o_sample_ready <= 1'b1;
            o_tx_data <= '0;
            tail_r <= '0;
        end else begin
            o_tx_valid <= hv_nxt;
            tail_v_r <= tv_nxt;
            o_sample_ready <= !tv_nxt;
            if (ld_head_tail) o_tx_data <= tail_r;
            else if (ld_head_new) o_tx_data <= frame;
            if (ld_tail_new) tail_r <= frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    property p_gen_trip;
        ##1 o_general_trip_out == (o_phase1_trip_out | o_phase2_trip_out | o_phase3_trip_out);
    endproperty
    a_gen_trip: assert property (p_gen_trip) else $error("general trip mismatch");
    property p_rx_bits;
        rx_ok && !fail_r |=> o_remote_rx_bit == $past(i_rx_data[FRAME_W-1:FR_CH_POS]);
    endproperty
    a_rx_bits: assert property (p_rx_bits) else $error("received channels wrong");
    property p_fail_quiet;
        o_link_failure_flag |-> !o_general_trip_out;
    endproperty
    a_fail_quiet: assert property (p_fail_quiet) else $error("trip during link failure");
    property p_disabled;
        !en_r |=> !o_general_trip_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("trip while disabled");
    property p_highset;
        live && hs[0] |=> o_phase1_trip_out;
    endproperty
    a_highset: assert property (p_highset) else $error("high-set did not trip");
    property p_restrained;
        rst_all && hs == 3'h0 |=> !o_general_trip_out;
    endproperty
    a_restrained: assert property (p_restrained) else $error("restraint ignored");
    property p_block;
        i_block |=> !o_general_trip_out;
    endproperty
    a_block: assert property (p_block) else $error("trip while blocked");
    property p_bad_run;
        i_rx_valid && !i_rx_good && bad_cnt_r == FAIL_CNT - 3'h1 |=> ##1 o_link_failure_flag;
    endproperty
    a_bad_run: assert property (p_bad_run) else $error("repeated errors not flagged");
    property p_tx_push;
        push |=> o_tx_valid;
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("frame not offered");

    c_trip: cover property (o_general_trip_out);
    c_recover: cover property (o_link_failure_flag ##1 !o_link_failure_flag);
    c_stall: cover property (!o_sample_ready && i_sample_valid);
    c_restraint: cover property (o_local_restraint);
endmodule // lnd_trip_decision

// ===== tb/lnd_remote_model.sv
`timescale 1ns/1ps
module lnd_remote_model
    import lnd_pkg::*;
(
    input wire logic i_core_clk, // clock
    input wire logic i_resetn, // reset, active low
    input wire logic i_tx_valid, // frame offered
    input wire logic [FRAME_W-1:0] i_tx_data, // frame offered
    output logic o_tx_ready = 1'b0, // frame taken
    output logic o_rx_valid = 1'b0, // frame to device
    output logic o_rx_good = 1'b0, // frame intact
    output logic [FRAME_W-1:0] o_rx_data = '0 // frame to device
);
    // steered by the bench
    logic [3*CW-1:0] rre = '0;
    logic [3*CW-1:0] rim = '0;
    logic rrst = 1'b0;
    logic [NCH-1:0] rch = '0;
    int nbad = 0;
    bit quiet = 1'b0;
    bit stall = 1'b0;
    bit slow = 1'b0;
    int tick = 0;
    logic [FRAME_W-1:0] got_q[$];
    ////////////////////////////////////////////////////////////
    // a frame every 8 clocks; idle data toggles so stale words never look fresh
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick <= 0;
            o_rx_valid <= 1'b0;
        end else begin
            tick <= (tick + 1) % 8;
            o_rx_valid <= (tick == 0) && !quiet;
            o_rx_good <= (nbad == 0);
            if (tick != 0)
                o_rx_data <= ~o_rx_data;
            else if (nbad == 0)
                o_rx_data <= {rch, rrst, rim, rre};
            else
                o_rx_data <= ~{rch, rrst, rim, rre};
            if (tick == 0 && nbad > 0)
                nbad <= nbad - 1;
        end
    end
    ////////////////////////////////////////////////////////////
    always @(posedge i_core_clk) begin
        if (i_resetn && i_tx_valid && o_tx_ready)
            got_q.push_back(i_tx_data);
        o_tx_ready <= i_resetn && !stall && (!slow || $urandom_range(1, 0) == 1);
    end
endmodule // lnd_remote_model

// ===== tb/line_diff_trip_decision_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module line_diff_trip_decision_tb;
    import lnd_pkg::*;
    localparam int TMO = 40;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_cfg_load = 1'b0;
    logic i_cfg_enable = 1'b0;
    logic [7:0] i_cfg_base = BASE_DEF;
    logic [7:0] i_cfg_slope_one = S1_DEF;
    logic [7:0] i_cfg_slope_two = S2_DEF;
    logic [9:0] i_cfg_slope_break_bias = BRK_DEF;
    logic [10:0] i_cfg_highset_diff_level = HS_DEF;
    logic [7:0] i_cfg_local_ratio = RATIO_DEF;
    logic [7:0] i_cfg_remote_ratio = RATIO_DEF;
    logic [7:0] i_cfg_h2_level = H2_DEF;
    logic [7:0] i_cfg_h5_level = H5_DEF;
    logic i_xfmr_variant_function = 1'b0;
    logic i_block = 1'b0;
    logic i_sample_valid = 1'b0;
    logic [3*CW-1:0] i_loc_re = '0;
    logic [3*CW-1:0] i_loc_im = '0;
    logic [3*CW-1:0] i_loc_h2_mag = '0;
    logic [3*CW-1:0] i_loc_h5_mag = '0;
    logic [NCH-1:0] i_remote_tx_bit = 12'h3C6;
    logic i_tx_ready, i_rx_valid, i_rx_good, o_sample_ready, o_tx_valid;
    logic [FRAME_W-1:0] i_rx_data, o_tx_data;
    logic o_phase1_trip_out, o_phase2_trip_out, o_phase3_trip_out, o_general_trip_out;
    logic o_link_failure_flag, o_local_restraint;
    logic [NCH-1:0] o_remote_rx_bit;
    int m_base = 30, m_s1 = 30, m_s2 = 70, m_brk = 200, m_hs = 800, m_lr = 100, m_rr = 100;
    bit m_en = 1'b0;
    bit ok;
    longint lre[3], lim[3], rre[3], rim[3];
    logic [FRAME_W-1:0] exp_q[$];

    lnd_trip_decision #(.RX_TIMEOUT(TMO)) dut_u (.*);
    lnd_remote_model rm_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready),
        .o_rx_valid(i_rx_valid), .o_rx_good(i_rx_good), .o_rx_data(i_rx_data));

    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    function automatic longint ab(longint a);
        return a < 0 ? -a : a;
    endfunction
    function automatic longint mx(longint a, longint b);
        return a > b ? a : b;
    endfunction
    // cheap magnitude max + min/4 + min/8; boundary cases are skipped below
    function automatic longint am(longint a, longint b);
        longint x;
        x = mx(ab(a), ab(b));
        return x + ((ab(a) + ab(b) - x) >>> 2) + ((ab(a) + ab(b) - x) >>> 3);
    endfunction
    function automatic int rnd(int lo, int hi);
        int k;
        k = $urandom % 8;
        return k == 0 ? lo - 1 : k == 1 ? hi + 1 : lo + int'($urandom % (hi - lo + 1));
    endfunction
    function automatic int okr(int v, int lo, int hi, int old);
        return (v >= lo && v <= hi) ? v : old;
    endfunction
    function automatic longint rv();
        return (longint'($urandom % 501) - 250) * (1 << ($urandom % 4));
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic done(string nm);
        $display("test %s done", nm);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic load_cfg();
        @(negedge i_core_clk);
        i_cfg_load = 1'b1;
        m_en = i_cfg_enable;
        m_base = okr(i_cfg_base, 10, 50, m_base);
        m_s1 = okr(i_cfg_slope_one, 10, 50, m_s1);
        m_s2 = okr(i_cfg_slope_two, 50, 100, m_s2);
        m_brk = okr(i_cfg_slope_break_bias, 100, 400, m_brk);
        m_hs = okr(i_cfg_highset_diff_level, 500, 1500, m_hs);
        m_lr = okr(i_cfg_local_ratio, 10, 200, m_lr);
        m_rr = okr(i_cfg_remote_ratio, 10, 200, m_rr);
        @(negedge i_core_clk);
        i_cfg_load = 1'b0;
    endtask
    task automatic load_rand();
        i_cfg_enable = ($urandom % 8 != 0);
        i_cfg_base = 8'(rnd(10, 50));
        i_cfg_slope_one = 8'(rnd(10, 50));
        i_cfg_slope_two = 8'(rnd(50, 100));
        i_cfg_slope_break_bias = 10'(rnd(100, 400));
        i_cfg_highset_diff_level = 11'(rnd(500, 1500));
        i_cfg_local_ratio = 8'(rnd(10, 200));
        i_cfg_remote_ratio = 8'(rnd(10, 200));
        i_cfg_h2_level = 8'(rnd(5, 80));
        i_cfg_h5_level = 8'(rnd(5, 80));
        load_cfg();
    endtask
    task automatic drive();
        for (int p = 0; p < 3; p++) begin
            i_loc_re[p*CW +: CW] = lre[p][CW-1:0];
            i_loc_im[p*CW +: CW] = lim[p][CW-1:0];
            rm_u.rre[p*CW +: CW] = rre[p][CW-1:0];
            rm_u.rim[p*CW +: CW] = rim[p][CW-1:0];
        end
    endtask
    task automatic offer(int wmax, output bit acc);
        int n;
        n = 0;
        @(negedge i_core_clk);
        i_sample_valid = 1'b1;
        while (o_sample_ready !== 1'b1 && n < wmax) begin
            @(negedge i_core_clk);
            n++;
        end
        acc = (o_sample_ready === 1'b1);
        if (acc)
            exp_q.push_back({i_remote_tx_bit, i_xfmr_variant_function
                & (|{i_loc_h2_mag, i_loc_h5_mag}), i_loc_im, i_loc_re});
        @(negedge i_core_clk);
        i_sample_valid = 1'b0;
    endtask
    task automatic wait_flag(logic v, int wmax, output bit hit);
        int n;
        n = 0;
        while (o_link_failure_flag !== v && n < wmax) begin
            @(negedge i_core_clk);
            n++;
        end
        hit = (o_link_failure_flag === v);
    endtask
    task automatic check_trips(bit fail);
        longint bias, d, t, k;
        bit rst, op, hs, nr, any_nr;
        logic [2:0] ex, got;
        bias = 0;
        any_nr = 0;
        for (int p = 0; p < 3; p++)
            bias = mx(bias, mx(am(lre[p] * m_lr, lim[p] * m_lr), am(rre[p] * m_rr, rim[p] * m_rr)));
        k = m_brk * 256;
        t = mx(m_base * 25600, bias <= k ? m_s1 * bias : m_s1 * k + m_s2 * (bias - k));
        rst = i_xfmr_variant_function & (|{i_loc_h2_mag, i_loc_h5_mag, rm_u.rrst});
        got = {o_phase3_trip_out, o_phase2_trip_out, o_phase1_trip_out};
        for (int p = 0; p < 3; p++) begin
            d = am(lre[p] * m_lr + rre[p] * m_rr, lim[p] * m_lr + rim[p] * m_rr);
            op = 100 * d > t;
            hs = d > m_hs * 256;
            nr = ab(100 * d - t) <= t / 32 || ab(d - m_hs * 256) <= m_hs * 8;
            ex[p] = m_en & !i_block & !fail & ((op & !rst) | hs);
            any_nr |= nr;
            if (!nr)
                `CHK("phase trip", ex[p], got[p])
        end
        if (!any_nr)
            `CHK("general trip", |ex, o_general_trip_out)
    endtask
    task automatic step();
        for (int p = 0; p < 3; p++) begin
            lre[p] = rv();
            lim[p] = rv();
            rre[p] = ($urandom % 2) ? -lre[p] : rv();
            rim[p] = ($urandom % 2) ? -lim[p] : rv();
            i_loc_h2_mag[p*CW +: CW] = ($urandom % 12 == 0) ? 16'hFFFF : 16'h0000;
            i_loc_h5_mag[p*CW +: CW] = ($urandom % 12 == 0) ? 16'hFFFF : 16'h0000;
        end
        drive();
        i_xfmr_variant_function = 1'($urandom % 2);
        i_block = ($urandom % 8 == 0);
        i_remote_tx_bit = NCH'($urandom);
        rm_u.rch = NCH'($urandom);
        rm_u.rrst = ($urandom % 6 == 0);
        if (!rm_u.rrst)
            offer(20, ok);
        repeat (12) @(negedge i_core_clk);
        check_trips(1'b0);
        `CHK("rx bits", rm_u.rch, o_remote_rx_bit)
        `CHK("link fail", 1'b0, o_link_failure_flag)
        // flag from the far end is left out: only the local decision is sent
        if (!rm_u.rrst)
            `CHK("restraint", exp_q[$][FR_RST_POS], o_local_restraint)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hD2D45D92));
        rm_u.rch = 12'hA5A;
        repeat (16) @(negedge i_core_clk);
        `CHK("trips in reset", 4'h0, {got_all()})
        `CHK("fail in reset", 1'b1, o_link_failure_flag)
        `CHK("ready in reset", 2'b10, {o_sample_ready, o_tx_valid})
        i_resetn = 1'b1;
        wait_flag(1'b0, 60, ok);
        `CHK("link up", 1'b1, ok)
        lre = '{2000, 2000, 2000};
        rre = lre;
        lim = '{0, 0, 0};
        rim = lim;
        drive();
        repeat (12) @(negedge i_core_clk);
        check_trips(1'b0);
        i_cfg_enable = 1'b1;
        load_cfg();
        repeat (2) @(negedge i_core_clk);
        check_trips(1'b0);
        done("defaults");
        rm_u.quiet = 1'b1;
        wait_flag(1'b1, TMO + 20, ok);
        `CHK("silence", 1'b1, ok)
        `CHK("rx in fail", 12'h000, o_remote_rx_bit)
        check_trips(1'b1);
        rm_u.quiet = 1'b0;
        wait_flag(1'b0, 60, ok);
        `CHK("recover", 1'b1, ok)
        rm_u.nbad = 2;
        repeat (40) @(negedge i_core_clk);
        `CHK("isolated bad", 1'b0, o_link_failure_flag)
        `CHK("rx kept", rm_u.rch, o_remote_rx_bit)
        rm_u.nbad = 3;
        wait_flag(1'b1, 40, ok);
        `CHK("bad run", 1'b1, ok)
        check_trips(1'b1);
        wait_flag(1'b0, 60, ok);
        `CHK("resume", 1'b1, ok)
        done("link");
        rm_u.stall = 1'b1;
        offer(20, ok);
        `CHK("take first", 1'b1, ok)
        i_remote_tx_bit = 12'h5A5;
        offer(20, ok);
        `CHK("take second", 1'b1, ok)
        offer(8, ok);
        `CHK("full refuses", 1'b0, ok)
        rm_u.stall = 1'b0;
        offer(20, ok);
        `CHK("take after drain", 1'b1, ok)
        done("buffer");
        rm_u.slow = 1'b1;
        for (int i = 0; i < 200; i++) begin
            if (i % 16 == 0)
                load_rand();
            step();
        end
        done("random");
        rm_u.slow = 1'b0;
        repeat (20) @(negedge i_core_clk);
        `CHK("tx count", exp_q.size(), rm_u.got_q.size())
        foreach (exp_q[i])
            `CHK("tx frame", exp_q[i], rm_u.got_q[i])
        done("tx");
        finish_test();
    end
    function automatic logic [3:0] got_all();
        return {o_phase1_trip_out, o_phase2_trip_out, o_phase3_trip_out, o_general_trip_out};
    endfunction
endmodule // line_diff_trip_decision_tb
